// [logic/bsr_pkg.sv]
package bsr_pkg;
  // timebase
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // interval lengths in their own units, then in cycles
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned HARD_PRESS_MS = 2000;
  localparam int unsigned LONG_PULSE_MS = 200;
  localparam int unsigned SOFT_PULSE_US = 100;
  localparam int unsigned CELL_FILT_US = 20;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned HARD_PRESS_CYC = HARD_PRESS_MS * CYC_PER_MS;
  localparam int unsigned LONG_PULSE_CYC = LONG_PULSE_MS * CYC_PER_MS;
  localparam int unsigned SOFT_PULSE_CYC = SOFT_PULSE_US * CYC_PER_US;
  localparam int unsigned CELL_FILT_CYC = CELL_FILT_US * CYC_PER_US;
  // counter widths and the two-pulse escalation point
  localparam int CNT_W = 25;
  localparam int FILT_W = 8;
  localparam logic [1:0] ESC_PULSES = 2'h2;
  // positions of the comparator inputs in the synchroniser vector
  localparam int IN_FB_LO = 0;
  localparam int IN_FB_HI = 1;
  localparam int IN_VCC_LOW = 2;
  localparam int IN_VCC_OK = 3;
  localparam int IN_CELL_LO = 4;
  localparam int IN_CELL_WARN = 5;
  localparam int IN_PB_LOW = 6;
  localparam int IN_PD_N = 7;
  localparam int IN_TRICKLE = 8;
  localparam int IN_CYC_DONE = 9;
  localparam int IN_LINE = 10;
  localparam int NUM_IN = 11;

  typedef enum logic [1:0] {ST_POWERUP, ST_NORMAL, ST_BACKUP, ST_LOCKOUT} bsr_mode_t;

  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    bsr_mode_t mode;
    logic boost_run;
    logic [1:0] pulses;
    logic peak_high;
    logic long_pulse;
    logic [CNT_W-1:0] press_cnt;
    logic [CNT_W-1:0] pulse_cnt;
    logic [FILT_W-1:0] filt_cnt;
    logic reset_oe;
    logic reset_hi;
    logic flag_oe;
    logic weak_oe;
    logic sw_hiz;
    logic pb_hiz;
    logic bak_hiz;
  } bsr_state_t;

  // reset value: power-up mode, every counter and output clear
  localparam bsr_state_t STATE_RST = '0;
endpackage : bsr_pkg

// [logic/bsr_supervisor.sv]
`timescale 1ns/10ps
module bsr_supervisor #(
  parameter int unsigned DEBOUNCE_CYC = bsr_pkg::DEBOUNCE_CYC,
  parameter int unsigned HARD_PRESS_CYC = bsr_pkg::HARD_PRESS_CYC,
  parameter int unsigned LONG_PULSE_CYC = bsr_pkg::LONG_PULSE_CYC,
  parameter int unsigned SOFT_PULSE_CYC = bsr_pkg::SOFT_PULSE_CYC,
  parameter int unsigned CELL_FILT_CYC = bsr_pkg::CELL_FILT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic fb_below_entry,
  input wire logic fb_above_exit,
  input wire logic supply_below_trip,
  input wire logic supply_above_recover,
  input wire logic cell_below_lockout,
  input wire logic cell_below_warn,
  input wire logic pushbutton_sense_low,
  input wire logic power_down_n,
  input wire logic trickle_charge,
  input wire logic boost_cycle_done,
  input wire logic reset_line_in,
  output logic reset_line_o,
  output logic reset_line_oe,
  output logic reset_high,
  output logic backup_flag_o,
  output logic backup_flag_oe,
  output logic weak_cell_warning_o,
  output logic weak_cell_warning_oe,
  output logic boost_en,
  output logic peak_current_high,
  output logic switch_node_hiz,
  output logic pushbutton_sense_hiz,
  output logic backup_output_hiz
);
  import bsr_pkg::*;

  // interval figures at counter width
  localparam logic [CNT_W-1:0] DEB_C = CNT_W'(DEBOUNCE_CYC);
  localparam logic [CNT_W-1:0] HARD_C = CNT_W'(HARD_PRESS_CYC);
  localparam logic [CNT_W-1:0] LONG_C = CNT_W'(LONG_PULSE_CYC);
  localparam logic [CNT_W-1:0] SOFT_C = CNT_W'(SOFT_PULSE_CYC);
  localparam logic [FILT_W-1:0] FILT_C = FILT_W'(CELL_FILT_CYC);

  bsr_state_t q; // registered state
  bsr_state_t d; // next state
  logic [NUM_IN-1:0] raw; // comparator levels as they arrive

  // synchronised comparator levels, read from the second stage only
  logic fb_lo;
  logic fb_hi;
  logic vcc_low;
  logic vcc_ok;
  logic cell_lo;
  logic cell_warn;
  logic pb_low;
  logic pd_n;
  logic trickle;
  logic cyc_done;
  logic line_hi;

  // gather pins; all come from the analog side, outside this clock
  always_comb begin
    raw = '0;
    raw[IN_FB_LO] = fb_below_entry;
    raw[IN_FB_HI] = fb_above_exit;
    raw[IN_VCC_LOW] = supply_below_trip;
    raw[IN_VCC_OK] = supply_above_recover;
    raw[IN_CELL_LO] = cell_below_lockout;
    raw[IN_CELL_WARN] = cell_below_warn;
    raw[IN_PB_LOW] = pushbutton_sense_low;
    raw[IN_PD_N] = power_down_n;
    raw[IN_TRICKLE] = trickle_charge;
    raw[IN_CYC_DONE] = boost_cycle_done;
    raw[IN_LINE] = reset_line_in;
  end

  assign fb_lo = q.s2[IN_FB_LO];
  assign fb_hi = q.s2[IN_FB_HI];
  assign vcc_low = q.s2[IN_VCC_LOW];
  assign vcc_ok = q.s2[IN_VCC_OK];
  assign cell_lo = q.s2[IN_CELL_LO];
  assign cell_warn = q.s2[IN_CELL_WARN];
  assign pb_low = q.s2[IN_PB_LOW];
  assign pd_n = q.s2[IN_PD_N];
  assign trickle = q.s2[IN_TRICKLE];
  assign cyc_done = q.s2[IN_CYC_DONE];
  assign line_hi = q.s2[IN_LINE];

  logic hard_evt; // pushbutton held past the hard-press time
  logic cell_trip; // low cell persisted in backup

  // next-state logic; outputs are derived from the next state so they
  // line up with the mode register in the same cycle
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    hard_evt = 1'b0;
    cell_trip = 1'b0;
    if (!pd_n) begin
      // power down: back to reset but for the synchronisers, with reset line pulled low, reset_high set and switch, pushbutton and backup pins hi-z
      d = STATE_RST;
      d.s1 = raw;
      d.s2 = q.s1;
      d.reset_oe = 1'b1;
      d.reset_hi = 1'b1;
      d.sw_hiz = 1'b1;
      d.pb_hiz = 1'b1;
      d.bak_hiz = 1'b1;
    end else begin
      // reset pulse timer runs down one per clock
      if (q.pulse_cnt != '0) begin
        d.pulse_cnt = q.pulse_cnt - 1'b1;
      end
      // pushbutton timing in every mode
      if (pb_low) begin
        if (q.press_cnt < HARD_C) begin
          d.press_cnt = q.press_cnt + 1'b1;
        end
        if (q.press_cnt == HARD_C - 1'b1) begin
          hard_evt = 1'b1;
          d.pulse_cnt = LONG_C;
          d.long_pulse = 1'b1;
        end
      end else begin
        // released: short presses give the short pulse only
        if (q.press_cnt >= DEB_C && q.press_cnt < HARD_C &&
            d.pulse_cnt < SOFT_C) begin
          d.pulse_cnt = SOFT_C;
        end
        d.press_cnt = '0;
      end
      // low-cell filter; ignored while the button holds the line down
      if (q.mode == ST_BACKUP && cell_lo && !pb_low) begin
        if (q.filt_cnt < FILT_C) begin
          d.filt_cnt = q.filt_cnt + 1'b1;
        end
      end else begin
        d.filt_cnt = '0;
      end
      cell_trip = (q.filt_cnt >= FILT_C);
      // mode selection; supply fault has highest priority
      if (vcc_low) begin
        d.mode = ST_LOCKOUT;
      end else begin
        unique case (q.mode)
          ST_POWERUP, ST_LOCKOUT: begin
            // main supply must be present again, not only vcc
            if (vcc_ok && !fb_lo) begin
              d.mode = ST_NORMAL;
              d.pulse_cnt = LONG_C;
              d.long_pulse = 1'b1;
            end
          end
          ST_NORMAL: begin
            if (fb_lo) begin
              d.mode = ST_BACKUP;
            end
          end
          ST_BACKUP: begin
            if (cell_trip) begin
              d.mode = ST_LOCKOUT;
            end else if (fb_hi) begin
              d.mode = ST_NORMAL;
            end
          end
        endcase
      end
      if (d.pulse_cnt == '0) begin
        d.long_pulse = 1'b0;
      end
      // boost converter control
      if (q.boost_run) begin
        if (hard_evt || d.mode == ST_LOCKOUT || d.mode == ST_POWERUP) begin
          // stop at once, no cycle completion
          d.boost_run = 1'b0;
          d.pulses = '0;
          d.peak_high = 1'b0;
        end else if (cyc_done) begin
          // decision only at the end of a switching cycle
          if (fb_lo && d.mode == ST_BACKUP) begin
            if (q.pulses < ESC_PULSES) begin
              d.pulses = q.pulses + 1'b1;
            end
            d.peak_high = (d.pulses == ESC_PULSES);
          end else begin
            d.boost_run = 1'b0;
            d.pulses = '0;
            d.peak_high = 1'b0;
          end
        end
      end else if (d.mode == ST_BACKUP && fb_lo && !d.long_pulse) begin
        d.boost_run = 1'b1;
        d.pulses = '0;
        d.peak_high = 1'b0;
      end
      // pin controls
      d.reset_oe = (d.mode == ST_POWERUP) || (d.mode == ST_LOCKOUT) ||
                   (d.pulse_cnt != '0);
      d.reset_hi = d.reset_oe || !line_hi;
      d.flag_oe = (d.mode != ST_BACKUP);
      d.weak_oe = cell_warn && !trickle;
      d.sw_hiz = (d.mode == ST_POWERUP) || (d.mode == ST_LOCKOUT);
      d.pb_hiz = 1'b0;
      d.bak_hiz = 1'b0;
    end
  end

  // one register for the whole state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // open-drain pins only ever pull low
  assign reset_line_o = 1'b0;
  assign backup_flag_o = 1'b0;
  assign weak_cell_warning_o = 1'b0;
  assign reset_line_oe = q.reset_oe;
  assign reset_high = q.reset_hi;
  assign backup_flag_oe = q.flag_oe;
  assign weak_cell_warning_oe = q.weak_oe;
  assign boost_en = q.boost_run;
  assign peak_current_high = q.peak_high;
  assign switch_node_hiz = q.sw_hiz;
  assign pushbutton_sense_hiz = q.pb_hiz;
  assign backup_output_hiz = q.bak_hiz;

  // checks on the mode and pin logic
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_backup_entry;
    (q.mode == ST_NORMAL && fb_lo && !vcc_low && pd_n) |=> q.mode == ST_BACKUP;
  endproperty
  a_backup_entry: assert property (p_backup_entry) else $error("no backup entry");

  property p_backup_exit;
    (q.mode == ST_BACKUP && fb_hi && !vcc_low && !cell_trip && pd_n)
      |=> (q.mode == ST_NORMAL && q.flag_oe);
  endproperty
  a_backup_exit: assert property (p_backup_exit) else $error("no backup exit");

  property p_flag_backup;
    q.mode == ST_BACKUP |-> !backup_flag_oe;
  endproperty
  a_flag_backup: assert property (p_flag_backup) else $error("flag pulled in backup");

  property p_lockout_reset;
    q.mode == ST_LOCKOUT |-> (reset_line_oe && reset_high && switch_node_hiz);
  endproperty
  a_lockout_reset: assert property (p_lockout_reset) else $error("lockout pins wrong");

  property p_exit_pulse;
    (q.mode == ST_LOCKOUT ##1 q.mode == ST_NORMAL) |-> reset_line_oe [*8];
  endproperty
  a_exit_pulse: assert property (p_exit_pulse) else $error("no long pulse");

  property p_hard_stop;
    (pd_n && pb_low && q.press_cnt == HARD_C - 1'b1)
      |=> (!boost_en && q.pulse_cnt == LONG_C);
  endproperty
  a_hard_stop: assert property (p_hard_stop) else $error("hard reset wrong");

  // only where no mode change is pending, so the pulse is the sole effect
  property p_soft_pulse;
    (pd_n && !pb_low && !vcc_low && q.press_cnt >= DEB_C && q.press_cnt < HARD_C &&
     q.pulse_cnt == '0 && ((q.mode == ST_NORMAL && !fb_lo) ||
     (q.mode == ST_BACKUP && !fb_hi && !cell_trip)))
      |=> (q.pulse_cnt == SOFT_C && q.mode == $past(q.mode));
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft pulse wrong");

  property p_debounce;
    (pd_n && !pb_low && q.press_cnt < DEB_C && q.pulse_cnt == '0 &&
     q.mode == ST_NORMAL && !vcc_low && !fb_lo) |=> q.pulse_cnt == '0;
  endproperty
  a_debounce: assert property (p_debounce) else $error("short press not ignored");

  property p_high_reset;
    (pd_n && !line_hi) |=> reset_high;
  endproperty
  a_high_reset: assert property (p_high_reset) else $error("high reset missed");

  property p_weak_cell;
    (pd_n && cell_warn && !trickle) |=> weak_cell_warning_oe;
  endproperty
  a_weak_cell: assert property (p_weak_cell) else $error("warning missed");

  property p_escalate;
    (q.boost_run && q.pulses == 2'h1 && cyc_done && fb_lo && pd_n &&
     q.mode == ST_BACKUP && !vcc_low && !cell_trip && !hard_evt) |=> peak_current_high;
  endproperty
  a_escalate: assert property (p_escalate) else $error("no escalation");
endmodule : bsr_supervisor

// [tb/bsr_far_side.sv]
`timescale 1ns/10ps
// far side: reset wire with pull-up plus the power stage end-of-cycle report
module bsr_far_side (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic boost_en,
  input wire logic reset_line_oe,
  input wire logic ext_pull,
  input wire logic slow,
  output logic reset_line_in,
  output logic boost_cycle_done
);
  logic [5:0] cnt_q; // cycles since the inductor began charging
  // pull-up wins unless the block or the processor sinks the wire
  assign reset_line_in = !(reset_line_oe || ext_pull);
  // inductor empties after a fixed time; slow mode stretches it past the checks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 6'h0;
      boost_cycle_done <= 1'b0;
    end else begin
      boost_cycle_done <= boost_en && (cnt_q == (slow ? 6'h27 : 6'h02));
      cnt_q <= (!boost_en || boost_cycle_done) ? 6'h0 : cnt_q + 6'h1;
    end
  end
endmodule : bsr_far_side

// [tb/test_bsr_supervisor.sv]
`timescale 1ns/10ps
// short counts keep the run near a thousand cycles
module test_bsr_supervisor;
  logic core_clk, nrst, fb_below_entry, fb_above_exit, supply_below_trip;
  logic supply_above_recover, cell_below_lockout, cell_below_warn;
  logic pushbutton_sense_low, power_down_n, trickle_charge, ext_pull, slow;
  logic reset_line_in, boost_cycle_done, reset_line_oe, reset_high, backup_flag_oe;
  logic weak_cell_warning_oe, boost_en, peak_current_high, switch_node_hiz;
  logic pushbutton_sense_hiz, backup_output_hiz;
  logic reset_line_o, backup_flag_o, weak_cell_warning_o; // open-drain data, always low
  logic boost_at; // boost state at the first high cycle of a pulse
  int err_count, n_checks, width;

  bsr_supervisor #(.DEBOUNCE_CYC(20), .HARD_PRESS_CYC(200), .LONG_PULSE_CYC(50),
    .SOFT_PULSE_CYC(10), .CELL_FILT_CYC(4)) dut (
    .core_clk(core_clk), .nrst(nrst), .fb_below_entry(fb_below_entry),
    .fb_above_exit(fb_above_exit), .supply_below_trip(supply_below_trip),
    .supply_above_recover(supply_above_recover), .cell_below_lockout(cell_below_lockout),
    .cell_below_warn(cell_below_warn), .pushbutton_sense_low(pushbutton_sense_low),
    .power_down_n(power_down_n), .trickle_charge(trickle_charge),
    .boost_cycle_done(boost_cycle_done), .reset_line_in(reset_line_in),
    .reset_line_o(reset_line_o), .reset_line_oe(reset_line_oe), .reset_high(reset_high),
    .backup_flag_o(backup_flag_o), .backup_flag_oe(backup_flag_oe),
    .weak_cell_warning_o(weak_cell_warning_o),
    .weak_cell_warning_oe(weak_cell_warning_oe), .boost_en(boost_en),
    .peak_current_high(peak_current_high), .switch_node_hiz(switch_node_hiz),
    .pushbutton_sense_hiz(pushbutton_sense_hiz), .backup_output_hiz(backup_output_hiz));

  bsr_far_side far (.core_clk(core_clk), .nrst(nrst), .boost_en(boost_en),
    .reset_line_oe(reset_line_oe), .ext_pull(ext_pull), .slow(slow),
    .reset_line_in(reset_line_in), .boost_cycle_done(boost_cycle_done));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // single-bit comparison
  task chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // cycle count comparison
  task chk_n(input int got, input int exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  // inputs move on falling edges only
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // wait for a reset pulse, then count its high cycles
  task pulse_len();
    int i;
    width = 0;
    for (i = 0; i < 400 && reset_line_oe !== 1'b1; i++) cyc(1);
    boost_at = boost_en;
    while (reset_line_oe === 1'b1 && width < 400) begin
      chk(reset_high, 1'b1);
      width++;
      cyc(1);
    end
  endtask : pulse_len

  // power-up or lockout exit must hold the wire for the long pulse, not release at once
  task exit_check();
    cyc(40);
    chk(reset_line_oe, 1'b1);
    cyc(30);
    chk(reset_line_oe, 1'b0);
    chk(switch_node_hiz, 1'b0);
    chk(backup_flag_oe, 1'b1);
  endtask : exit_check

  task t_powerup();
    cyc(1);
    chk(switch_node_hiz, 1'b1);
    chk(boost_en, 1'b0);
    chk(reset_line_o, 1'b0);
    chk(backup_flag_o, 1'b0);
    chk(weak_cell_warning_o, 1'b0);
    // feedback drops while the power-up pulse runs: backup, but no boost yet
    fb_above_exit = 1'b0;
    fb_below_entry = 1'b1;
    cyc(10);
    chk(backup_flag_oe, 1'b0);
    chk(boost_en, 1'b0);
    fb_below_entry = 1'b0;
    fb_above_exit = 1'b1;
    exit_check();
    $display("powerup test done");
  endtask : t_powerup

  task t_soft();
    pushbutton_sense_low = 1'b1;
    cyc(10);
    pushbutton_sense_low = 1'b0;
    cyc(20);
    chk(reset_line_oe, 1'b0);
    pushbutton_sense_low = 1'b1;
    cyc(30);
    pushbutton_sense_low = 1'b0;
    pulse_len();
    chk_n(width, 10);
    chk(backup_flag_oe, 1'b1);
    ext_pull = 1'b1;
    cyc(5);
    chk(reset_high, 1'b1);
    chk(reset_line_oe, 1'b0);
    ext_pull = 1'b0;
    cyc(5);
    chk(reset_high, 1'b0);
    $display("soft reset test done");
  endtask : t_soft

  task t_boost();
    slow = 1'b0;
    fb_above_exit = 1'b0;
    fb_below_entry = 1'b1;
    cyc(4);
    chk(backup_flag_oe, 1'b0);
    chk(boost_en, 1'b1);
    chk(peak_current_high, 1'b0);
    cyc(30);
    chk(peak_current_high, 1'b1);
    fb_below_entry = 1'b0;
    cyc(20);
    chk(boost_en, 1'b0);
    chk(backup_flag_oe, 1'b0);
    slow = 1'b1;
    fb_below_entry = 1'b1;
    cyc(5);
    chk(boost_en, 1'b1);
    chk(peak_current_high, 1'b0);
    fb_below_entry = 1'b0;
    fb_above_exit = 1'b1;
    cyc(5);
    chk(backup_flag_oe, 1'b1);
    chk(boost_en, 1'b1);
    cyc(40);
    chk(boost_en, 1'b0);
    $display("boost test done");
  endtask : t_boost

  task t_hard();
    fb_above_exit = 1'b0;
    fb_below_entry = 1'b1;
    cyc(6);
    chk(boost_en, 1'b1);
    // a short press in backup must leave the mode and the boost alone
    pushbutton_sense_low = 1'b1;
    cyc(30);
    pushbutton_sense_low = 1'b0;
    pulse_len();
    chk_n(width, 10);
    chk(boost_at, 1'b1);
    chk(boost_en, 1'b1);
    chk(backup_flag_oe, 1'b0);
    pushbutton_sense_low = 1'b1;
    pulse_len();
    chk(boost_at, 1'b0);
    chk_n(width, 50);
    pushbutton_sense_low = 1'b0;
    cyc(20);
    chk(reset_line_oe, 1'b0);
    $display("hard reset test done");
  endtask : t_hard

  task t_cell();
    cell_below_warn = 1'b1;
    cyc(4);
    chk(weak_cell_warning_oe, 1'b1);
    trickle_charge = 1'b1;
    cyc(4);
    chk(weak_cell_warning_oe, 1'b0);
    trickle_charge = 1'b0;
    cell_below_lockout = 1'b1;
    cyc(2);
    cell_below_lockout = 1'b0;
    cyc(10);
    chk(reset_line_oe, 1'b0);
    cell_below_lockout = 1'b1;
    cyc(12);
    chk(reset_line_oe, 1'b1);
    chk(boost_en, 1'b0);
    chk(switch_node_hiz, 1'b1);
    chk(backup_flag_oe, 1'b1);
    cell_below_lockout = 1'b0;
    cell_below_warn = 1'b0;
    fb_below_entry = 1'b0;
    fb_above_exit = 1'b1;
    exit_check();
    $display("cell lockout test done");
  endtask : t_cell

  task t_undervoltage_lockout();
    supply_below_trip = 1'b1;
    supply_above_recover = 1'b0;
    cyc(5);
    chk(reset_line_oe, 1'b1);
    cyc(100);
    chk(reset_line_oe, 1'b1);
    chk(switch_node_hiz, 1'b1);
    supply_below_trip = 1'b0;
    supply_above_recover = 1'b1;
    exit_check();
    $display("undervoltage test done");
  endtask : t_undervoltage_lockout

  task t_power_down_n();
    power_down_n = 1'b0;
    cyc(5);
    chk(pushbutton_sense_hiz, 1'b1);
    chk(backup_output_hiz, 1'b1);
    chk(switch_node_hiz, 1'b1);
    power_down_n = 1'b1;
    exit_check();
    $display("shutdown test done");
  endtask : t_power_down_n

  // verdict and end of run
  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // watchdog, well beyond the expected run of under 2000 cycles
  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end

  initial begin
    {fb_below_entry, supply_below_trip, cell_below_lockout, cell_below_warn} = 4'h0;
    {pushbutton_sense_low, trickle_charge, ext_pull, slow} = 4'h0;
    {fb_above_exit, supply_above_recover, power_down_n} = 3'h7;
    err_count = 0;
    n_checks = 0;
    nrst = 1'b0;
    cyc(12);
    nrst = 1'b1;
    t_powerup();
    t_soft();
    t_boost();
    t_hard();
    t_cell();
    t_undervoltage_lockout();
    t_power_down_n();
    end_of_test();
  end
endmodule : test_bsr_supervisor
